// file: hw/cmt_pkg.sv
// Shared constants for the carrier mark/space modulator.
package cmt_pkg;

    // Register byte addresses on the bus.
    localparam logic [7:0] OFS_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] OFS_UPPER_NIBBLES  = 8'h04;
    localparam logic [7:0] OFS_MARK_LOW       = 8'h08;
    localparam logic [7:0] OFS_SPACE_LOW      = 8'h0C;
    localparam int         ADDR_DECODE_BITS   = 8;

    // Control/status bit positions.
    localparam int BIT_CYCLE_END      = 7;
    localparam int BIT_HALF_RATE      = 6;
    localparam int BIT_EXT_IRQ_MASK   = 5;
    localparam int BIT_EXT_SPACE      = 4;
    localparam int BIT_BASEBAND       = 3;
    localparam int BIT_FSK_MODE       = 2;
    localparam int BIT_CYCLE_IRQ_EN   = 1;
    localparam int BIT_GEN_ENABLE     = 0;

    // Upper nibble register layout.
    localparam int MARK_NIBBLE_LSB    = 4;
    localparam int SPACE_NIBBLE_LSB   = 0;

    // Reset values.
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [11:0] PERIOD_RESET  = 12'h000;

    // Period counter width and time mode divider.
    localparam int         PERIOD_WIDTH = 12;
    localparam int         TIME_DIVIDE  = 8;
    localparam int         TIME_DIV_W   = 3;
    localparam logic [2:0] TIME_DIV_LAST =
        3'(TIME_DIVIDE - 1);

    // AHB-Lite encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef enum logic [1:0] {
        MOD_IDLE,
        MOD_RUN,
        MOD_STOPPING
    } mod_state_t;

endpackage

// file: hw/ahb_access_front.sv
// AHB-Lite slave front end: captures the address phase, one wait state.
`timescale 1ns/10ps
module ahb_access_front
    import cmt_pkg::*;
(
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic                             access_pulse,
    output logic                             access_write,
    output logic [ADDR_DECODE_BITS-1:0]      access_addr
);

    logic accept;

    // NONSEQ and SEQ both count.
    assign accept = hsel & hready & htrans[1];

    // The wait state spares a read-after-write bypass.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else if (accept) begin
            hreadyout <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            access_pulse <= 1'b0;
            access_write <= 1'b0;
            access_addr  <= '0;
        end else begin
            access_pulse <= accept;
            if (accept) begin
                access_write <= hwrite;
                access_addr  <= haddr[ADDR_DECODE_BITS-1:0];
            end
        end
    end

endmodule

// file: hw/modulator_rate_divider.sv
// Transmitter clock prescaler and time mode divide-by-eight tick.
`timescale 1ns/10ps
module modulator_rate_divider
    import cmt_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic run,
    input  wire logic half_rate,
    output logic      stage_enable,
    output logic      time_tick
);

    logic                  half_phase_reg;
    logic [TIME_DIV_W-1:0] div_reg;
    logic                  stage_next;

    // With the halving prescaler on, only every other clock advances.
    assign stage_next = run & (~half_rate | half_phase_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_phase_reg <= 1'b0;
        end else if (!run) begin
            half_phase_reg <= 1'b0;
        end else begin
            half_phase_reg <= ~half_phase_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_enable <= 1'b0;
            div_reg      <= '0;
            time_tick    <= 1'b0;
        end else begin
            stage_enable <= stage_next;
            time_tick    <= 1'b0;
            if (!run) begin
                div_reg <= '0;
            end else if (stage_next) begin
                div_reg <= div_reg + 1'b1;
                if (div_reg == TIME_DIV_LAST) begin
                    time_tick <= 1'b1;
                end
            end
        end
    end

endmodule

// file: hw/carrier_mark_space_modulator.sv
// Carrier mark/space modulator with its AHB-Lite register file.
//
// Notes on behaviour
// RULE1 - Time mode: mark (M+1)*8, space S*8.
// RULE2 - Half rate doubles all durations.
// RULE3 - FSK counts carrier periods.
// RULE4 - FSK: mark expiry swaps carrier settings.
// RULE5 - FSK zero space: no gap.
// RULE6 - Extended space: whole period is space.
// RULE7 - Extended space clear acts next period.
// RULE8 - Space match ends cycle, flags, reloads.
// RULE9 - Cycle end copies space buffer.
// RULE10 - Mark buffer feeds counter at reload.
// RULE11 - Status read, low-byte access clears flag.
// RULE12 - Flag with enable requests interrupt.
// RULE13 - Software clears flag in its handler.
// RULE14 - Mask blocks pin and keyscan interrupts.
// RULE15 - Baseband holds carrier high.
// RULE16 - Mode bit: one FSK, zero time.
// RULE17 - Unbuffered bits unchanged while sending.
// RULE18 - Enable starts continuous running.
// RULE19 - Disable finishes cycle, output low.
// RULE20 - Registers programmed before enabling.
// RULE21 - Twelve-bit buffers via three byte registers.
// RULE22 - Upper nibbles: mark high, space low.
// RULE23 - Down counter, complement compare to space.
// RULE24 - Time baseband_enable one eighth; zero allowed.
// RULE25 - Gate synchronised to carrier.
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module carrier_mark_space_modulator
    import cmt_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        carrier_in,
    input  wire logic        carrier_period_tick,
    input  wire logic        ext_irq_in,
    input  wire logic        keyscan_irq_in,
    output logic             modulator_out,
    output logic             carrier_enable,
    output logic             carrier_force_high,
    output logic             carrier_select_secondary,
    output logic             carrier_clock_enable,
    output logic             cycle_irq,
    output logic             ext_irq_out,
    output logic             keyscan_irq_out
);

    logic                          access_pulse;
    logic                          access_write;
    logic [ADDR_DECODE_BITS-1:0]   access_addr;
    logic                          time_tick;

    logic [7:0]                    control_reg;
    logic                          cycle_end_reg;
    logic [PERIOD_WIDTH-1:0]       mark_buf_reg;
    logic [PERIOD_WIDTH-1:0]       space_buf_reg;
    logic [PERIOD_WIDTH-1:0]       active_space_reg;
    logic [PERIOD_WIDTH-1:0]       count_reg;
    logic                          in_space_reg;
    logic                          ext_space_active_reg;
    logic                          clear_armed_reg;
    logic                          gate_reg;
    mod_state_t                    state_reg;

    logic                          half_rate;
    logic                          ext_mask;
    logic                          ext_space_bit;
    logic                          baseband;
    logic                          fsk_mode;
    logic                          irq_enable;
    logic                          gen_enable;

    logic                          running;
    logic                          start;
    logic                          tick;
    logic                          mark_expire;
    logic                          cycle_end;
    logic                          gate_request;
    logic                          gate_next;
    logic                          wr_control;
    logic                          rd_control;
    logic                          low_byte_access;
    logic [PERIOD_WIDTH-1:0]       count_dec;

    // True when the complemented, still-decrementing count has reached
    // the active space value.
    function automatic logic space_match(
        input logic [PERIOD_WIDTH-1:0] count,
        input logic [PERIOD_WIDTH-1:0] space
    );
        space_match = (~count == space);
    endfunction

    ahb_access_front u_front (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .hsel         (hsel),
        .haddr        (haddr),
        .htrans       (htrans),
        .hwrite       (hwrite),
        .hready       (hready),
        .hreadyout    (hreadyout),
        .access_pulse (access_pulse),
        .access_write (access_write),
        .access_addr  (access_addr)
    );

    modulator_rate_divider u_divider (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .run          (running),
        .half_rate    (half_rate), // see RULE2
        .stage_enable (carrier_clock_enable),
        .time_tick    (time_tick)
    );

    assign half_rate     = control_reg[BIT_HALF_RATE];
    assign ext_mask      = control_reg[BIT_EXT_IRQ_MASK];
    assign ext_space_bit = control_reg[BIT_EXT_SPACE];
    assign baseband      = control_reg[BIT_BASEBAND];
    assign fsk_mode      = control_reg[BIT_FSK_MODE];
    assign irq_enable    = control_reg[BIT_CYCLE_IRQ_EN];
    assign gen_enable    = control_reg[BIT_GEN_ENABLE];

    assign wr_control = access_pulse & access_write &
                        (access_addr == OFS_CONTROL_STATUS);
    assign rd_control = access_pulse & ~access_write &
                        (access_addr == OFS_CONTROL_STATUS);
    // Either direction of access to a low-byte register counts.
    assign low_byte_access = access_pulse &
                             ((access_addr == OFS_MARK_LOW) |
                              (access_addr == OFS_SPACE_LOW));

    // Writes; the flag bit is read only.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_reg <= CONTROL_RESET;
        end else if (wr_control) begin
            control_reg <= hwdata[7:0];
            control_reg[BIT_CYCLE_END] <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mark_buf_reg  <= PERIOD_RESET;
            space_buf_reg <= PERIOD_RESET;
        end else if (access_pulse && access_write) begin
            unique case (access_addr)
                OFS_UPPER_NIBBLES: begin // see RULE21 see RULE22
                    mark_buf_reg[11:8]  <= hwdata[MARK_NIBBLE_LSB +: 4];
                    space_buf_reg[11:8] <= hwdata[SPACE_NIBBLE_LSB +: 4];
                end
                OFS_MARK_LOW: begin
                    mark_buf_reg[7:0] <= hwdata[7:0]; // see RULE21
                end
                OFS_SPACE_LOW: begin
                    space_buf_reg[7:0] <= hwdata[7:0]; // see RULE21
                end
                default: begin
                end
            endcase
        end
    end

    // Read data is set in the wait state; holes read zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hresp  <= HRESP_OKAY;
        end else if (access_pulse && !access_write) begin
            hresp <= HRESP_OKAY;
            unique case (access_addr)
                OFS_CONTROL_STATUS: begin
                    hrdata <= {24'h00_0000, cycle_end_reg,
                               control_reg[6:0]};
                end
                OFS_UPPER_NIBBLES: begin
                    hrdata <= {24'h00_0000, mark_buf_reg[11:8],
                               space_buf_reg[11:8]};
                end
                OFS_MARK_LOW: begin
                    hrdata <= {24'h00_0000, mark_buf_reg[7:0]};
                end
                OFS_SPACE_LOW: begin
                    hrdata <= {24'h00_0000, space_buf_reg[7:0]};
                end
                default: begin
                    hrdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // A status read arms the clear; the next access
    // fires it on a low byte or disarms it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clear_armed_reg <= 1'b0;
        end else if (access_pulse) begin
            clear_armed_reg <= rd_control;
        end
    end

    // Run control: enable starts, disable waits for the cycle end.
    assign running = (state_reg != MOD_IDLE);
    assign start   = (state_reg == MOD_IDLE) & gen_enable;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= MOD_IDLE;
        end else begin
            unique case (state_reg)
                MOD_IDLE: begin
                    if (gen_enable) begin
                        state_reg <= MOD_RUN; // see RULE18
                    end
                end
                MOD_RUN: begin
                    if (!gen_enable) begin
                        state_reg <= MOD_STOPPING;
                    end
                end
                MOD_STOPPING: begin
                    if (gen_enable) begin
                        state_reg <= MOD_RUN;
                    end else if (cycle_end) begin
                        state_reg <= MOD_IDLE; // see RULE19
                    end
                end
            endcase
        end
    end

    // The counting baseband_enable follows the mode bit directly.
    assign tick = running &
                  (fsk_mode ? carrier_period_tick // see RULE3 see RULE16
                            : time_tick);         // see RULE1 see RULE24

    assign count_dec   = count_reg - 1'b1;
    assign mark_expire = tick & ~in_space_reg & (count_reg == '0);
    // A zero space matches at once on underflow, so no gap is made.
    assign cycle_end   = tick &
        (in_space_reg ? space_match(count_dec, active_space_reg)
                      : (count_reg == '0) &&
                        space_match(count_dec, active_space_reg));

    // Down counter and its mark/space phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg        <= PERIOD_RESET;
            active_space_reg <= PERIOD_RESET;
            in_space_reg     <= 1'b0;
        end else if (start || cycle_end) begin
            count_reg        <= mark_buf_reg;   // see RULE8 see RULE10
            active_space_reg <= space_buf_reg;  // see RULE9
            in_space_reg     <= 1'b0;
        end else if (tick) begin
            count_reg <= count_dec;             // see RULE23
            if (mark_expire) begin
                in_space_reg <= 1'b1;           // see RULE23
            end
        end
    end

    // Extended space is sampled only at reload, so both
    // edits of the bit act on period boundaries.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_space_active_reg <= 1'b0;
        end else if (start || cycle_end) begin
            ext_space_active_reg <= ext_space_bit; // see RULE6 see RULE7
        end
    end

    // In FSK mode, the primary/secondary carrier choice alternates on every mark expiry; time mode holds it on primary.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            carrier_select_secondary <= 1'b0;
        end else if (start || !fsk_mode) begin
            carrier_select_secondary <= 1'b0;
        end else if (mark_expire) begin
            carrier_select_secondary <= ~carrier_select_secondary;
            // see RULE4 see RULE5
        end
    end

    // End-of-cycle flag; a new cycle end beats a clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cycle_end_reg <= 1'b0;
        end else if (cycle_end) begin
            cycle_end_reg <= 1'b1;                  // see RULE8
        end else if (clear_armed_reg && low_byte_access) begin
            cycle_end_reg <= 1'b0;                  // see RULE11
        end
    end

    // The request follows the flag, gated by the enable already in force.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cycle_irq <= 1'b0;
        end else begin
            cycle_irq <= irq_enable &
                         (cycle_end_reg |
                          (cycle_end & ~wr_control)); // see RULE12
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_irq_out     <= 1'b0;
            keyscan_irq_out <= 1'b0;
        end else begin
            ext_irq_out     <= ext_irq_in & ~ext_mask;     // see RULE14
            keyscan_irq_out <= keyscan_irq_in & ~ext_mask; // see RULE14
        end
    end

    // Gate opens at once, but while running a carrier burst is never cut mid-pulse.
    assign gate_request = running & ~in_space_reg &
                          ~ext_space_active_reg &
                          ~(start | cycle_end);
    assign gate_next = gate_request |
                       (gate_reg & running & carrier_in & ~baseband);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_reg <= 1'b0;
        end else if (!running) begin
            gate_reg <= 1'b0;
        end else begin
            gate_reg <= gate_next;                   // see RULE25
        end
    end

    // Output is low outside the gate and when stopped.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            modulator_out      <= 1'b0;
            carrier_enable     <= 1'b0;
            carrier_force_high <= 1'b0;
        end else begin
            modulator_out <= running & gate_next &
                             (baseband | carrier_in); // see RULE25
            // Restarting the generator with the gate keeps the burst's
            // first pulse whole.
            carrier_enable <= running & ~baseband &
                              (gate_next | gate_reg); // see RULE15
            carrier_force_high <= baseband;           // see RULE15
        end
    end

    // Transfer size is ignored.
    logic unused_hsize;
    assign unused_hsize = ^hsize;

endmodule

// file: tb/cmt_checker.sv
// Port-level assertions for the carrier mark/space modulator.
`timescale 1ns/10ps
module cmt_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        carrier_in,
    input wire logic        ext_irq_in,
    input wire logic        keyscan_irq_in,
    input wire logic        modulator_out,
    input wire logic        carrier_enable,
    input wire logic        carrier_force_high,
    input wire logic        ext_irq_out,
    input wire logic        keyscan_irq_out
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus response not OKAY");

    property p_wait;
        hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout;
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait state not one cycle");

    property p_upper_zero;
        hrdata[31:8] == 24'h00_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("read data upper bits not zero");

    property p_rdata_time;
        $changed(hrdata) |-> !$past(hreadyout);
    endproperty
    a_rdata_time: assert property (p_rdata_time)
        else $error("read data changed outside a transfer");

    property p_ext_quiet;
        !ext_irq_in |=> !ext_irq_out;
    endproperty
    a_ext_quiet: assert property (p_ext_quiet)
        else $error("pin interrupt passed without a source");

    property p_key_quiet;
        !keyscan_irq_in |=> !keyscan_irq_out;
    endproperty
    a_key_quiet: assert property (p_key_quiet)
        else $error("keyscan interrupt passed without a source");

    property p_baseband_enable_gen;
        carrier_force_high [*2] |-> !carrier_enable;
    endproperty
    a_baseband_enable_gen: assert property (p_baseband_enable_gen)
        else $error("generator runs in baseband");

    property p_out_low;
        !carrier_in && !carrier_force_high ##1 !carrier_force_high
            |-> !modulator_out;
    endproperty
    a_out_low: assert property (p_out_low)
        else $error("output high while carrier low");
endmodule

// file: tb/carrier_gen_model.sv
// Carrier generator model on the modulator's far side.
`timescale 1ns/10ps
module carrier_gen_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic step,
    input wire logic secondary,
    output logic     carrier,
    output logic     tick
);
    logic [2:0] cnt;
    logic [2:0] half_len;

    // Unequal settings make a missed swap show up as a rate change.
    assign half_len = secondary ? 3'h3 : 3'h2;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 3'h0;
            carrier <= 1'b0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (!run) begin
                cnt <= 3'h0;
                carrier <= 1'b0;
            end else if (step) begin
                if (cnt == half_len - 3'h1) begin
                    cnt <= 3'h0;
                    carrier <= ~carrier;
                    tick <= carrier;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end
        end
    end
endmodule

// file: tb/carrier_mark_space_modulator_test.sv
// Testbench for the carrier mark/space modulator.
`timescale 1ns/10ps
module carrier_mark_space_modulator_test;
    import cmt_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        ext_irq_in, keyscan_irq_in, ext_irq_out, keyscan_irq_out;
    logic        carrier_in, carrier_period_tick, modulator_out, cycle_irq;
    logic        carrier_enable, carrier_force_high;
    logic        carrier_select_secondary, carrier_clock_enable;
    int          bad_count, comparisons, hi, lo, n;

    assign hready = hreadyout;
    carrier_mark_space_modulator uut (.*);
    carrier_gen_model partner (.hclk, .hresetn, .run(carrier_enable),
        .step(carrier_clock_enable), .secondary(carrier_select_secondary),
        .carrier(carrier_in), .tick(carrier_period_tick));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic check(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= 32'(a);
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [7:0] a, e);
        bus(1'b0, a, 32'h0000_0000);
        check(nm, 32'(e), q);
    endtask

    // Times one mark and its space in clocks.
    task automatic measure;
        hi = 0;
        lo = 0;
        while (modulator_out !== 1'b0) @(posedge hclk);
        while (modulator_out !== 1'b1) @(posedge hclk);
        while (modulator_out === 1'b1) begin
            hi++;
            @(posedge hclk);
        end
        while (modulator_out === 1'b0) begin
            lo++;
            @(posedge hclk);
        end
    endtask

    task automatic count_high(input int span);
        hi = 0;
        repeat (span) begin
            @(posedge hclk);
            hi += int'(modulator_out === 1'b1);
        end
    endtask

    task automatic t_reset;
        logic [7:0] ofs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
        foreach (ofs[i]) rd("reset value", ofs[i], 8'h00);
    endtask

    task automatic t_regs;
        bus(1'b1, OFS_UPPER_NIBBLES, 32'h0000_00A5);
        rd("nibbles", OFS_UPPER_NIBBLES, 8'hA5);
        bus(1'b1, OFS_MARK_LOW, 32'h0000_003C);
        rd("mark low", OFS_MARK_LOW, 8'h3C);
        bus(1'b1, OFS_SPACE_LOW, 32'h0000_00C3);
        rd("space low", OFS_SPACE_LOW, 8'hC3);
        ext_irq_in <= 1'b1;
        keyscan_irq_in <= 1'b1;
        bus(1'b1, OFS_CONTROL_STATUS, 32'h0000_0020);
        rd("mask set", OFS_CONTROL_STATUS, 8'h20);
        check("pin irq masked", 0, ext_irq_out);
        check("key irq masked", 0, keyscan_irq_out);
        bus(1'b1, OFS_CONTROL_STATUS, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        check("pin irq passed", 1, ext_irq_out);
        check("key irq passed", 1, keyscan_irq_out);
    endtask

    task automatic t_time;
        bus(1'b1, OFS_UPPER_NIBBLES, 32'h0000_0000);
        bus(1'b1, OFS_MARK_LOW, 32'h0000_0002);
        bus(1'b1, OFS_SPACE_LOW, 32'h0000_0003);
        bus(1'b1, OFS_CONTROL_STATUS, 32'h0000_000B);
        n = 0;
        while (cycle_irq !== 1'b1 && n < 200) begin
            n++;
            @(posedge hclk);
        end
        check("cycle irq", 1, cycle_irq);
        rd("flag set", OFS_CONTROL_STATUS, 8'h8B);
        rd("mark low", OFS_MARK_LOW, 8'h02);
        rd("flag clear", OFS_CONTROL_STATUS, 8'h0B);
        check("irq clear", 0, cycle_irq);
        measure;
        check("mark time", 24, hi);
        check("space time", 24, lo);
        bus(1'b1, OFS_MARK_LOW, 32'h0000_0005);
        bus(1'b1, OFS_CONTROL_STATUS, 32'h0000_0049);
        measure;
        check("half mark", 96, hi);
        check("half space", 48, lo);
        check("irq off", 0, cycle_irq);
    endtask

    task automatic t_exspace;
        bus(1'b1, OFS_CONTROL_STATUS, 32'h0000_0019);
        repeat (120) @(posedge hclk);
        count_high(150);
        check("no marks", 0, hi);
        bus(1'b1, OFS_CONTROL_STATUS, 32'h0000_0009);
        measure;
        check("mark again", 48, hi);
        check("space again", 24, lo);
        bus(1'b1, OFS_CONTROL_STATUS, 32'h0000_0008);
        repeat (80) @(posedge hclk);
        count_high(60);
        check("stopped low", 0, hi);
        check("clocks off", 0, carrier_clock_enable);
    endtask

    task automatic t_fsk;
        logic last;
        bus(1'b1, OFS_MARK_LOW, 32'h0000_0001);
        bus(1'b1, OFS_SPACE_LOW, 32'h0000_0000);
        bus(1'b1, OFS_CONTROL_STATUS, 32'h0000_0005);
        last = carrier_select_secondary;
        n = 0;
        repeat (300) begin
            @(posedge hclk);
            n += int'(carrier_select_secondary !== last);
            last = carrier_select_secondary;
        end
        check("swaps", 1, 32'(n >= 2));
        check("gen on", 1, carrier_enable);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        conclude;
    end

    initial begin
        {hresetn, hsel, hwrite, ext_irq_in, keyscan_irq_in} = 5'h00;
        {haddr, hwdata} = 64'h0000_0000_0000_0000;
        htrans = 2'h0;
        hsize = 3'h2;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_regs;
        t_time;
        t_exspace;
        t_fsk;
        conclude;
    end
endmodule

bind carrier_mark_space_modulator cmt_checker chk (.*);
